/* urbc_rx_count_regs.sv */
// Receive byte-count registers, reception-valid flags and IN buffer flush
`timescale 1ns/1ns
`default_nettype none
`include "urbc_params.svh"

module urbc_rx_count_regs
    import urbc_pkg::*;
(
    input wire logic core_clk_i,
    input wire logic rst_n_i,
    input wire logic [31:0] reg_addr_i,
    input wire logic [31:0] reg_wdata_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    output logic [31:0] reg_rdata_o,
    input wire logic rx_done_i,
    input wire logic [2:0] rx_ep_i,
    input wire logic rx_buf_i,
    input wire logic [`URBC_CNT_MAX_W-1:0] rx_len_i,
    output logic [`URBC_NUM_EP-1:0] rx_stall_a_o,
    output logic [`URBC_NUM_EP-1:0] rx_stall_b_o,
    output logic [`URBC_NUM_EP-1:0] in_flush_o,
    output logic irq_o
);

    localparam int NS = `URBC_NUM_SLOT;
    localparam int NE = `URBC_NUM_EP;

    // Slot order: endpoints 1..6 buffer A, then 1..6 buffer B
    localparam int SLOT_W [NS] = '{
        `URBC_EP1_CNT_W, `URBC_EP2_CNT_W, `URBC_EP3_CNT_W,
        `URBC_EP4_CNT_W, `URBC_EP5_CNT_W, `URBC_EP6_CNT_W,
        `URBC_EP1_CNT_W, `URBC_EP2_CNT_W, `URBC_EP3_CNT_W,
        `URBC_EP4_CNT_W, `URBC_EP5_CNT_W, `URBC_EP6_CNT_W
    };

    // Earlier entries win where two registers share an address
    localparam logic [31:0] SLOT_ADDR [NS] = '{
        `URBC_ADDR_EP1_A, `URBC_ADDR_EP2_A, `URBC_ADDR_EP3_A,
        `URBC_ADDR_EP4_A, `URBC_ADDR_EP5_A, `URBC_ADDR_EP6_A,
        `URBC_ADDR_EP1_B, `URBC_ADDR_EP2_B, `URBC_ADDR_EP3_B,
        `URBC_ADDR_EP4_B, `URBC_ADDR_EP5_B, `URBC_ADDR_EP6_B
    };

    logic [NS-1:0] slot_valid;
    urbc_count_t slot_count [NS];
    logic [NS-1:0] rx_sel;
    logic [NS-1:0] rx_take;
    logic rx_drop;
    logic [NS-1:0] addr_hit;
    logic any_hit;
    urbc_word_t valid_word;
    urbc_irq_vec_t evt_vec;
    urbc_word_t rd_mux;
    logic wr_valid;
    logic wr_flush;

    urbc_slot_if slot_bus [NS] ();
    urbc_irq_if irq_bus ();

    function automatic int slot_ep(input int s);
        return (s % `URBC_SLOTS_PER_BUF) + 1;
    endfunction

    function automatic int slot_buf(input int s);
        return s / `URBC_SLOTS_PER_BUF;
    endfunction

    function automatic int valid_pos(input int s);
        return slot_buf(s) * `URBC_VALID_B_LSB + slot_ep(s);
    endfunction

    // Target slot of an incoming OUT reception
    always_comb
    begin
        rx_sel = '0;
        for (int s = 0; s < NS; s++)
        begin
            if (rx_done_i && rx_ep_i == 3'(slot_ep(s)) && rx_buf_i == 1'(slot_buf(s)))
                rx_sel[s] = 1'b1;
        end
    end

    // A buffer still awaiting acknowledge takes nothing new
    assign rx_take = rx_sel & ~slot_valid;
    assign rx_drop = |(rx_sel & slot_valid);

    // Register address decode, first match wins
    always_comb
    begin
        addr_hit = '0;
        any_hit = 1'b0;
        for (int s = 0; s < NS; s++)
        begin
            if (!any_hit && reg_addr_i == SLOT_ADDR[s])
            begin
                addr_hit[s] = 1'b1;
                any_hit = 1'b1;
            end
        end
    end

    assign wr_valid = reg_wr_i && reg_addr_i == `URBC_ADDR_RX_VALID;
    assign wr_flush = reg_wr_i && reg_addr_i == `URBC_ADDR_IN_FLUSH;

    generate
        for (genvar g = 0; g < NS; g++)
        begin : g_slot
            assign slot_bus[g].cap = rx_take[g];
            assign slot_bus[g].cap_len = rx_len_i;
            assign slot_bus[g].wr = reg_wr_i & addr_hit[g];
            assign slot_bus[g].wr_data = reg_wdata_i[`URBC_CNT_MAX_W-1:0];
            assign slot_bus[g].ack = wr_valid & reg_wdata_i[valid_pos(g)];
            assign slot_valid[g] = slot_bus[g].valid;
            assign slot_count[g] = slot_bus[g].count;

            urbc_count_slot #(
                .W(SLOT_W[g])
            ) u_slot (
                .core_clk_i(core_clk_i),
                .rst_n_i(rst_n_i),
                .bus(slot_bus[g].slot)
            );
        end
    endgenerate

    // Valid flags in their word layout; endpoint 0 lives elsewhere
    always_comb
    begin
        valid_word = '0;
        for (int s = 0; s < NS; s++)
            valid_word[valid_pos(s)] = slot_valid[s];
    end

    assign rx_stall_a_o = valid_word[NE-1:0];
    assign rx_stall_b_o = valid_word[`URBC_VALID_B_LSB+NE-1:`URBC_VALID_B_LSB];

    // Flush pulses last one cycle and never read back
    always_ff @(posedge core_clk_i)
    begin
        if (!rst_n_i)
            in_flush_o <= '0;
        else if (wr_flush)
            in_flush_o <= reg_wdata_i[NE-1:0];
        else
            in_flush_o <= '0;
    end

    // Interrupt events: each capture, plus a reception arriving while stalled
    always_comb
    begin
        evt_vec = '0;
        for (int s = 0; s < NS; s++)
            evt_vec[valid_pos(s)] = rx_take[s];
        evt_vec[`URBC_IRQ_OVERRUN_BIT] = rx_drop;
    end

    assign irq_bus.evt = evt_vec;
    assign irq_bus.clr_wr = reg_wr_i && reg_addr_i == `URBC_ADDR_IRQ_CLEAR;
    assign irq_bus.en_wr = reg_wr_i && reg_addr_i == `URBC_ADDR_IRQ_ENABLE;
    assign irq_bus.wdata = reg_wdata_i;

    urbc_irq u_irq (
        .core_clk_i(core_clk_i),
        .rst_n_i(rst_n_i),
        .bus(irq_bus.unit)
    );

    assign irq_o = irq_bus.irq;

    // Read data selection; write-only and unmapped words read zero
    always_comb
    begin
        rd_mux = `URBC_WORD_RESET;
        if (any_hit)
        begin
            for (int s = 0; s < NS; s++)
            begin
                if (addr_hit[s])
                    rd_mux = {{(32-`URBC_CNT_MAX_W){1'b0}}, slot_count[s]};
            end
        end
        else if (reg_addr_i == `URBC_ADDR_RX_VALID)
            rd_mux = valid_word;
        else if (reg_addr_i == `URBC_ADDR_IRQ_STATUS)
            rd_mux = {{(32-`URBC_IRQ_W){1'b0}}, irq_bus.status};
        else if (reg_addr_i == `URBC_ADDR_IRQ_ENABLE)
            rd_mux = {{(32-`URBC_IRQ_W){1'b0}}, irq_bus.enable};
        else
            rd_mux = `URBC_WORD_RESET;
    end

    // Read data stand only in the cycle after the strobe
    always_ff @(posedge core_clk_i)
    begin
        if (!rst_n_i)
            reg_rdata_o <= `URBC_WORD_RESET;
        else if (reg_rd_i)
            reg_rdata_o <= rd_mux;
        else
            reg_rdata_o <= `URBC_WORD_RESET;
    end

endmodule

`default_nettype wire

/* urbc_params.svh */
// Address map, field layouts and reset values for the receive byte-count block
`ifndef URBC_PARAMS_SVH
`define URBC_PARAMS_SVH

`define URBC_ADDR_EP1_A 32'h4001107C
`define URBC_ADDR_EP2_A 32'h40011080
`define URBC_ADDR_EP3_A 32'h40011084
`define URBC_ADDR_EP4_A 32'h40011084
`define URBC_ADDR_EP5_A 32'h4001108C
`define URBC_ADDR_EP6_A 32'h40011090
`define URBC_ADDR_EP1_B 32'h40011098
`define URBC_ADDR_EP2_B 32'h4001109C
`define URBC_ADDR_EP3_B 32'h400110A0
`define URBC_ADDR_EP4_B 32'h400110A0
`define URBC_ADDR_EP5_B 32'h400110A8
`define URBC_ADDR_EP6_B 32'h400110AC
`define URBC_ADDR_RX_VALID 32'h40011048
`define URBC_ADDR_IN_FLUSH 32'h40011064
`define URBC_ADDR_IRQ_STATUS 32'h400110B0
`define URBC_ADDR_IRQ_CLEAR 32'h400110B4
`define URBC_ADDR_IRQ_ENABLE 32'h400110B8

`define URBC_EP1_CNT_W 4
`define URBC_EP2_CNT_W 4
`define URBC_EP3_CNT_W 7
`define URBC_EP4_CNT_W 6
`define URBC_EP5_CNT_W 7
`define URBC_EP6_CNT_W 10
`define URBC_CNT_MAX_W 10

`define URBC_NUM_EP 7
`define URBC_NUM_SLOT 12
`define URBC_SLOTS_PER_BUF 6
`define URBC_VALID_B_LSB 8
`define URBC_IRQ_OVERRUN_BIT 16
`define URBC_IRQ_W 17
`define URBC_COUNT_RESET 10'h000
`define URBC_WORD_RESET 32'h00000000

`endif

/* urbc_pkg.sv */
// Types shared by the receive byte-count block
`include "urbc_params.svh"

package urbc_pkg;
    typedef logic [`URBC_CNT_MAX_W-1:0] urbc_count_t;
    typedef logic [`URBC_IRQ_W-1:0] urbc_irq_vec_t;
    typedef logic [31:0] urbc_word_t;
    typedef enum logic {URBC_BUF_A, URBC_BUF_B} urbc_buf_t;
endpackage

/* urbc_if.sv */
// Internal carriers between the byte-count top and its slot and interrupt modules
`timescale 1ns/1ns
`default_nettype none

interface urbc_slot_if;
    import urbc_pkg::*;
    logic cap;
    urbc_count_t cap_len;
    logic wr;
    urbc_count_t wr_data;
    logic ack;
    urbc_count_t count;
    logic valid;
    modport ctrl (output cap, cap_len, wr, wr_data, ack, input count, valid);
    modport slot (input cap, cap_len, wr, wr_data, ack, output count, valid);
endinterface

interface urbc_irq_if;
    import urbc_pkg::*;
    urbc_irq_vec_t evt;
    logic clr_wr;
    logic en_wr;
    urbc_word_t wdata;
    urbc_irq_vec_t status;
    urbc_irq_vec_t enable;
    logic irq;
    modport ctrl (output evt, clr_wr, en_wr, wdata, input status, enable, irq);
    modport unit (input evt, clr_wr, en_wr, wdata, output status, enable, irq);
endinterface

`default_nettype wire

/* urbc_count_slot.sv */
// One endpoint buffer: received byte count and its reception-valid flag
`timescale 1ns/1ns
`default_nettype none
`include "urbc_params.svh"

module urbc_count_slot
    import urbc_pkg::*;
#(
    parameter int W = 4
)
(
    input wire logic core_clk_i,
    input wire logic rst_n_i,
    urbc_slot_if.slot bus
);

    logic [W-1:0] count;
    logic valid;

    // Only the low W bits exist; upper bits stay zero
    always_ff @(posedge core_clk_i)
    begin
        if (!rst_n_i)
            count <= W'(`URBC_COUNT_RESET);
        else if (bus.cap)
            count <= bus.cap_len[W-1:0];
        else if (bus.wr)
            count <= bus.wr_data[W-1:0];
    end

    // Capture wins over a same-cycle acknowledge
    always_ff @(posedge core_clk_i)
    begin
        if (!rst_n_i)
            valid <= 1'b0;
        else if (bus.cap)
            valid <= 1'b1;
        else if (bus.ack)
            valid <= 1'b0;
    end

    generate
        if (W < `URBC_CNT_MAX_W)
        begin : g_pad
            assign bus.count = {{(`URBC_CNT_MAX_W-W){1'b0}}, count};
        end
        else
        begin : g_full
            assign bus.count = count;
        end
    endgenerate
    assign bus.valid = valid;

endmodule

`default_nettype wire

/* urbc_irq.sv */
// Sticky event status, enable mask and level interrupt
`timescale 1ns/1ns
`default_nettype none
`include "urbc_params.svh"

module urbc_irq
    import urbc_pkg::*;
(
    input wire logic core_clk_i,
    input wire logic rst_n_i,
    urbc_irq_if.unit bus
);

    urbc_irq_vec_t status;
    urbc_irq_vec_t enable;
    urbc_irq_vec_t clr_mask;

    assign clr_mask = bus.clr_wr ? bus.wdata[`URBC_IRQ_W-1:0] : '0;

    // New events win over a same-cycle clear
    always_ff @(posedge core_clk_i)
    begin
        if (!rst_n_i)
            status <= '0;
        else
            status <= (status & ~clr_mask) | bus.evt;
    end

    always_ff @(posedge core_clk_i)
    begin
        if (!rst_n_i)
            enable <= '0;
        else if (bus.en_wr)
            enable <= bus.wdata[`URBC_IRQ_W-1:0];
    end

    assign bus.status = status;
    assign bus.enable = enable;
    assign bus.irq = |(status & enable);

endmodule

`default_nettype wire

/* urbc_rx_count_regs_chk.sv */
// Port-level assertions for the receive byte-count registers
`timescale 1ns/1ns
`default_nettype none
`include "urbc_params.svh"
module urbc_rx_count_regs_chk
(
    input wire logic core_clk_i,
    input wire logic rst_n_i,
    input wire logic [31:0] reg_addr_i,
    input wire logic [31:0] reg_wdata_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    input wire logic [31:0] reg_rdata_o,
    input wire logic rx_done_i,
    input wire logic [2:0] rx_ep_i,
    input wire logic rx_buf_i,
    input wire logic [`URBC_CNT_MAX_W-1:0] rx_len_i,
    input wire logic [`URBC_NUM_EP-1:0] rx_stall_a_o,
    input wire logic [`URBC_NUM_EP-1:0] rx_stall_b_o,
    input wire logic [`URBC_NUM_EP-1:0] in_flush_o,
    input wire logic irq_o
);
    default clocking cb @(posedge core_clk_i); endclocking
    default disable iff (!rst_n_i);
    logic flush_wr;
    logic ack_wr;
    logic cap_ok;
    assign flush_wr = reg_wr_i && reg_addr_i == `URBC_ADDR_IN_FLUSH;
    assign ack_wr = reg_wr_i && reg_addr_i == `URBC_ADDR_RX_VALID;
    assign cap_ok = rx_done_i && rx_ep_i >= 3'h1 && rx_ep_i <= 3'h6;
    // Lone flush write followed by an idle cycle
    sequence s_lone_flush;
        flush_wr ##1 !flush_wr;
    endsequence
    sequence s_pulse_then_low;
        in_flush_o == $past(reg_wdata_i[6:0]) ##1 in_flush_o == 7'h00;
    endsequence
    a_flush_pulse_shape: assert property (s_lone_flush |-> s_pulse_then_low)
        else $error("flush pulse wrong");
    a_flush_needs_write: assert property (in_flush_o != 7'h00 |-> $past(flush_wr))
        else $error("flush without write");
    a_rdata_idle_zero: assert property (!reg_rd_i |=> reg_rdata_o == 32'h00000000)
        else $error("read data outside read slot");
    a_capture_stall_a: assert property (cap_ok && !rx_buf_i && !ack_wr |=> rx_stall_a_o[$past(rx_ep_i)])
        else $error("buffer A not stalled");
    a_capture_stall_b: assert property (cap_ok && rx_buf_i && !ack_wr |=> rx_stall_b_o[$past(rx_ep_i)])
        else $error("buffer B not stalled");
    a_ep0_never_stalls: assert property (!rx_stall_a_o[0] && !rx_stall_b_o[0])
        else $error("endpoint 0 stalled");
    a_ack_clears_stall: assert property (ack_wr && !rx_done_i |=>
        (rx_stall_a_o & $past(reg_wdata_i[6:0])) == 7'h00 && (rx_stall_b_o & $past(reg_wdata_i[14:8])) == 7'h00)
        else $error("acknowledge did not release");
    a_stall_only_acked: assert property ((($past(rx_stall_a_o) & ~rx_stall_a_o) != 7'h00) |-> $past(ack_wr))
        else $error("stall dropped without acknowledge");
    a_stall_needs_rx: assert property (((rx_stall_a_o & ~$past(rx_stall_a_o)) != 7'h00) |->
        $past(rx_done_i) && !$past(rx_buf_i))
        else $error("stall raised without reception");
endmodule
bind urbc_rx_count_regs urbc_rx_count_regs_chk u_chk (.core_clk_i, .rst_n_i, .reg_addr_i, .reg_wdata_i,
    .reg_wr_i, .reg_rd_i, .reg_rdata_o, .rx_done_i, .rx_ep_i, .rx_buf_i, .rx_len_i, .rx_stall_a_o,
    .rx_stall_b_o, .in_flush_o, .irq_o);
`default_nettype wire

/* urbc_host_model.sv */
// Host-side model delivering OUT receptions to the block
`timescale 1ns/1ns
`default_nettype none
`include "urbc_params.svh"
module urbc_host_model
(
    input wire logic core_clk_i,
    input wire logic [`URBC_NUM_EP-1:0] stall_a_i,
    input wire logic [`URBC_NUM_EP-1:0] stall_b_i,
    output logic done_o,
    output logic [2:0] ep_o,
    output logic buf_o,
    output logic [`URBC_CNT_MAX_W-1:0] len_o
);
    initial
    begin
        done_o = 1'b0;
        ep_o = 3'h0;
        buf_o = 1'b0;
        len_o = 10'h000;
    end
    // Stalled buffer is skipped unless an overrun is wanted
    task automatic send(input logic [2:0] ep, input logic b, input logic [9:0] len, input logic overrun);
        if ((b ? stall_b_i[ep] : stall_a_i[ep]) && !overrun) return;
        @(posedge core_clk_i);
        done_o <= 1'b1;
        ep_o <= ep;
        buf_o <= b;
        len_o <= len;
        @(posedge core_clk_i);
        done_o <= 1'b0;
        ep_o <= ~ep;
        buf_o <= ~b;
        len_o <= ~len;
    endtask
endmodule
`default_nettype wire

/* testbench.sv */
// Self-checking bench for the receive byte-count registers
`timescale 1ns/1ns
`default_nettype none
`include "urbc_params.svh"
module testbench;
    localparam logic [31:0] ADDR_A [7] = '{32'h0, `URBC_ADDR_EP1_A, `URBC_ADDR_EP2_A, `URBC_ADDR_EP3_A,
        `URBC_ADDR_EP4_A, `URBC_ADDR_EP5_A, `URBC_ADDR_EP6_A};
    localparam logic [31:0] ADDR_B [7] = '{32'h0, `URBC_ADDR_EP1_B, `URBC_ADDR_EP2_B, `URBC_ADDR_EP3_B,
        `URBC_ADDR_EP4_B, `URBC_ADDR_EP5_B, `URBC_ADDR_EP6_B};
    localparam int WD [7] = '{0, `URBC_EP1_CNT_W, `URBC_EP2_CNT_W, `URBC_EP3_CNT_W, `URBC_EP4_CNT_W,
        `URBC_EP5_CNT_W, `URBC_EP6_CNT_W};
    logic clk, rst_n, wr, rd, done, bsel, irq;
    logic [31:0] addr, wdata, rdata;
    logic [2:0] ep;
    logic [9:0] len;
    logic [6:0] sa, sb, fl;
    int fail_count, checks;
    urbc_rx_count_regs dut (.core_clk_i(clk), .rst_n_i(rst_n), .reg_addr_i(addr), .reg_wdata_i(wdata),
        .reg_wr_i(wr), .reg_rd_i(rd), .reg_rdata_o(rdata), .rx_done_i(done), .rx_ep_i(ep), .rx_buf_i(bsel),
        .rx_len_i(len), .rx_stall_a_o(sa), .rx_stall_b_o(sb), .in_flush_o(fl), .irq_o(irq));
    urbc_host_model host (.core_clk_i(clk), .stall_a_i(sa), .stall_b_i(sb), .done_o(done), .ep_o(ep),
        .buf_o(bsel), .len_o(len));
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp)
        begin
            fail_count++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic wr_reg(input logic [31:0] a, input logic [31:0] d);
        @(posedge clk);
        wr <= 1'b1;
        addr <= a;
        wdata <= d;
        @(posedge clk);
        wr <= 1'b0;
        #1;
    endtask
    task automatic rd_chk(input logic [31:0] a, input logic [31:0] exp);
        @(posedge clk);
        rd <= 1'b1;
        addr <= a;
        @(posedge clk);
        rd <= 1'b0;
        #1;
        chk(rdata, exp);
    endtask
    task automatic t_reset_values;
        @(posedge clk);
        #1;
        chk({10'h0, irq, fl, sb, sa}, 32'h0);
        rd_chk(`URBC_ADDR_RX_VALID, 32'h0);
        for (int e = 1; e < 7; e++)
        begin
            rd_chk(ADDR_A[e], 32'h0);
            rd_chk(ADDR_B[e], 32'h0);
        end
    endtask
    // Both buffers filled to or past each field width, read once valid for every endpoint except 4
    task automatic t_widths;
        logic [31:0] m;
        for (int e = 1; e < 7; e++)
        begin
            m = (32'h1 << WD[e]) - 32'h1;
            host.send(3'(e), 1'b0, 10'h3FF, 1'b0);
            host.send(3'(e), 1'b1, 10'h2AA, 1'b0);
            @(posedge clk);
            #1;
            chk({30'h0, sa[e], sb[e]}, 32'h3);
            if (e != 4)
            begin
                rd_chk(ADDR_A[e], 32'h3FF & m);
                rd_chk(ADDR_B[e], 32'h2AA & m);
            end
        end
        rd_chk(`URBC_ADDR_RX_VALID, 32'h00007E7E);
        wr_reg(`URBC_ADDR_RX_VALID, 32'h00007E7E);
        chk({18'h0, sb, sa}, 32'h0);
        rd_chk(`URBC_ADDR_RX_VALID, 32'h0);
    endtask
    task automatic t_overrun;
        wr_reg(`URBC_ADDR_IRQ_CLEAR, 32'hFFFFFFFF);
        wr_reg(`URBC_ADDR_IRQ_ENABLE, 32'h00010000);
        rd_chk(`URBC_ADDR_IRQ_ENABLE, 32'h00010000);
        host.send(3'h2, 1'b0, 10'h005, 1'b0);
        host.send(3'h2, 1'b0, 10'h009, 1'b1);
        #1;
        chk({24'h0, irq, sa}, 32'h84);
        rd_chk(`URBC_ADDR_EP2_A, 32'h5);
        rd_chk(`URBC_ADDR_IRQ_STATUS, 32'h00010004);
        wr_reg(`URBC_ADDR_IRQ_CLEAR, 32'h00010000);
        chk({31'h0, irq}, 32'h0);
        wr_reg(`URBC_ADDR_RX_VALID, 32'h00000004);
        chk({25'h0, sa}, 32'h0);
        wr_reg(`URBC_ADDR_EP2_A, 32'hFFFFFFFF);
        rd_chk(`URBC_ADDR_EP2_A, 32'hF);
    endtask
    task automatic t_flush;
        wr_reg(`URBC_ADDR_IN_FLUSH, 32'hFFFFFFFF);
        chk({25'h0, fl}, 32'h7F);
        @(posedge clk);
        #1;
        chk({25'h0, fl}, 32'h0);
        rd_chk(`URBC_ADDR_IN_FLUSH, 32'h0);
        rd_chk(32'h40011000, 32'h0);
    endtask
    task automatic tally_and_finish;
        $display("checks=%0d fail_count=%0d", checks, fail_count);
        if (fail_count == 0 && checks > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    initial
    begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end
    initial
    begin
        repeat (5000) @(posedge clk);
        fail_count++;
        tally_and_finish();
    end
    initial
    begin
        fail_count = 0;
        checks = 0;
        rst_n = 1'b0;
        wr = 1'b0;
        rd = 1'b0;
        addr = 32'h0;
        wdata = 32'h0;
        repeat (20) @(posedge clk);
        rst_n <= 1'b1;
        t_reset_values();
        t_widths();
        t_overrun();
        t_flush();
        tally_and_finish();
    end
endmodule
`default_nettype wire
